//--- core/psds_core.sv
/*
 * PWM output-conditioning stage: auto-shutdown with restart, half-bridge
 * dead band and single-output pulse steering over four pins.
 * Assumes a raw PWM level and a period-start pulse from the period timer,
 * all inputs synchronous to REF_CLK, and a one-cycle register port.
 */
`timescale 1ns/1ns

// Function
// - Shutdown flag is set on an event; while set, outputs hold shutdown state.
// - Source select: off, comparator one, two, either, pin low, or pin ORed.
// - Pair A/C shutdown state: 00 low, 01 high, 1x tri-state.
// - Pair B/D shutdown state in low bits, same encoding as A/C.
// - With comparator two sync on, its shutdown waits for the Timer1 sync.
// - Shutdown is level based and persists while the source level stays.
// - Software writes to the flag are ignored while a condition persists.
// - After restart, PWM resumes only at the start of the next period.
// - Auto-restart on: flag clears in hardware once the condition goes.
// - Dead band delays only inactive-to-active edges in half-bridge mode.
// - Dead-band count is instruction cycles from scheduled to actual activation.
// - Auto-restart enable resets to 0 under crystal two-speed start or fail-safe.
// - Steering only with unit mode 11 and output config 00.
// - Each steering enable routes the polarised PWM to its pin, else port.
// - Steered pins take polarity from the output polarity field.
// - Steering sync 1 applies changes at next period, 0 immediately.
// - In steering, shutdown affects only steered pins; others stay port.
// - Enabled pins move to shutdown state without waiting for a period.
// - A software write of 1 to the flag is a shutdown event.
// - Half-bridge drives PWM on A and its complement on B, both dead-banded.
module psds_core
    import psds_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       REF_CLK,
    input  wire logic       RST_B,
    input  wire logic       CLK_EN,
    // Register port
    input  wire logic [1:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    // PWM unit side
    input  wire logic       PWM_IN,
    input  wire logic       PERIOD_START,
    input  wire logic [1:0] UNIT_MODE_FIELD,
    input  wire logic [1:0] OUTPUT_POLARITY_FIELD,
    input  wire logic [1:0] OUTPUT_CONFIG_FIELD,
    // Shutdown sources
    input  wire logic       COMPARATOR_ONE,
    input  wire logic       COMPARATOR_TWO,
    input  wire logic       EXT_INT_PIN,
    input  wire logic       COMPARATOR2_SYNC_ENABLE,
    input  wire logic       TIMER1_SYNC_PULSE,
    input  wire logic       STARTUP_RESTART_CLEAR,
    // Port fallback
    input  wire logic [3:0] PORT_DATA,
    input  wire logic [3:0] PIN_DIRECTION_BITS,
    // Pins D..A
    output logic      [3:0] PWM_PIN_OUT,
    output logic      [3:0] PWM_PIN_OE
);

    // Pin drive {oe, value}: port, shutdown state or polarised PWM
    function automatic logic [1:0] psds_pin_drive(
        input logic       own,
        input logic       halt,
        input logic [1:0] shut_state,
        input logic       level,
        input logic       low_act,
        input logic       port,
        input logic       dir
    );
        logic [1:0] drv;
        drv = {~dir, port};
        if (own && halt)
        begin
            drv = {~dir & ~shut_state[1], shut_state == 2'b01};
        end
        else if (own)
        begin
            drv = {~dir, level ^ low_act};
        end
        return drv;
    endfunction : psds_pin_drive

    // Control registers
    logic            sd_flag_reg;
    logic [2:0]      sd_src_reg;
    logic [1:0]      sd_ac_reg;
    logic [1:0]      sd_bd_reg;
    logic            auto_rs_reg;
    logic [DB_W-1:0] db_count_reg;
    logic            steer_sync_reg;
    logic [3:0]      steer_req_reg;
    // Internal state
    logic [3:0]      steer_eff_reg;
    logic            run_reg;
    logic            cmp2_held_reg;
    logic [3:0]      tcy_cnt_reg;
    logic [DB_W-1:0] db_cnt_reg [2];
    logic [1:0]      db_act_reg;
    logic [7:0]      rdata_reg;
    logic [3:0]      pin_out_reg;
    logic [3:0]      pin_oe_reg;
    // Combinational
    logic            wr_shut;
    logic            wr_rs;
    logic            wr_steer;
    logic            cmp2_eff;
    logic            pin_low;
    logic            sd_cond;
    logic            halt;
    logic            pwm_mode;
    logic            single;
    logic            half;
    logic            tcy_tick;
    logic [1:0]      db_sched;
    logic [3:0]      own;
    logic [3:0]      level;
    logic [3:0]      low_act;

    assign REG_RDATA   = rdata_reg;
    assign PWM_PIN_OUT = pin_out_reg;
    assign PWM_PIN_OE  = pin_oe_reg;

    // Register write decode
    assign wr_shut  = REG_WR && (REG_ADDR == ADDR_SHUTDOWN);
    assign wr_rs    = REG_WR && (REG_ADDR == ADDR_RESTART);
    assign wr_steer = REG_WR && (REG_ADDR == ADDR_STEER);

    // Mode decode
    assign pwm_mode = (UNIT_MODE_FIELD == MODE_PWM);
    assign single   = pwm_mode && (OUTPUT_CONFIG_FIELD == CFG_SINGLE);
    assign half     = pwm_mode && (OUTPUT_CONFIG_FIELD == CFG_HALF);

    // Comparator two may be held off until the Timer1 sync point
    assign cmp2_eff = COMPARATOR2_SYNC_ENABLE ? cmp2_held_reg : COMPARATOR_TWO;
    assign pin_low  = ~EXT_INT_PIN;

    // Source select; level based, so the condition lasts as long as the level
    always_comb
    begin
        unique case (psds_src_t'(sd_src_reg))
            SRC_OFF:      sd_cond = 1'b0;
            SRC_CMP1:     sd_cond = COMPARATOR_ONE;
            SRC_CMP2:     sd_cond = cmp2_eff;
            SRC_CMP_ANY:  sd_cond = COMPARATOR_ONE | cmp2_eff;
            SRC_PIN:      sd_cond = pin_low;
            SRC_PIN_CMP1: sd_cond = pin_low | COMPARATOR_ONE;
            SRC_PIN_CMP2: sd_cond = pin_low | cmp2_eff;
            SRC_PIN_ALL:  sd_cond = pin_low | COMPARATOR_ONE | cmp2_eff;
        endcase
    end

    // Condition joins halt directly so pins leave PWM at the next edge
    assign halt = sd_cond | sd_flag_reg | ~run_reg;

    // Comparator two sample point
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            cmp2_held_reg <= 1'b0;
        else if (CLK_EN && TIMER1_SYNC_PULSE)
            cmp2_held_reg <= COMPARATOR_TWO;
    end

    // Shutdown flag: set wins over any clear
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            sd_flag_reg <= SHUTDOWN_RST[SD_FLAG_BIT];
        else if (CLK_EN)
        begin
            if (sd_cond)
                sd_flag_reg <= 1'b1;
            else if (wr_shut)
                sd_flag_reg <= REG_WDATA[SD_FLAG_BIT];
            else if (auto_rs_reg)
                sd_flag_reg <= 1'b0;
        end
    end

    // Shutdown configuration fields
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sd_src_reg <= SHUTDOWN_RST[SD_SRC_LSB +: 3];
            sd_ac_reg  <= SHUTDOWN_RST[SD_AC_LSB +: 2];
            sd_bd_reg  <= SHUTDOWN_RST[SD_BD_LSB +: 2];
        end
        else if (CLK_EN && wr_shut)
        begin
            sd_src_reg <= REG_WDATA[SD_SRC_LSB +: 3];
            sd_ac_reg  <= REG_WDATA[SD_AC_LSB +: 2];
            sd_bd_reg  <= REG_WDATA[SD_BD_LSB +: 2];
        end
    end

    // Restart gate: output resumes only on a period boundary
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            run_reg <= 1'b1;
        else if (CLK_EN)
        begin
            if (sd_cond || sd_flag_reg)
                run_reg <= 1'b0;
            else if (PERIOD_START)
                run_reg <= 1'b1;
        end
    end

    // Restart and dead-band control; start-up clear beats a write
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            auto_rs_reg  <= RESTART_RST[RS_AUTO_BIT];
            db_count_reg <= RESTART_RST[RS_DB_LSB +: DB_W];
        end
        else if (CLK_EN)
        begin
            if (STARTUP_RESTART_CLEAR)
                auto_rs_reg <= 1'b0;
            else if (wr_rs)
                auto_rs_reg <= REG_WDATA[RS_AUTO_BIT];
            if (wr_rs)
                db_count_reg <= REG_WDATA[RS_DB_LSB +: DB_W];
        end
    end

    // Steering request as written
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            steer_sync_reg <= STEER_RST[ST_SYNC_BIT];
            steer_req_reg  <= STEER_RST[ST_EN_LSB +: 4];
        end
        else if (CLK_EN && wr_steer)
        begin
            steer_sync_reg <= REG_WDATA[ST_SYNC_BIT];
            steer_req_reg  <= REG_WDATA[ST_EN_LSB +: 4];
        end
    end

    // Effective steering: immediate cuts may leave a partial pulse
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            steer_eff_reg <= STEER_RST[ST_EN_LSB +: 4];
        else if (CLK_EN)
        begin
            if (wr_steer && !REG_WDATA[ST_SYNC_BIT])
                steer_eff_reg <= REG_WDATA[ST_EN_LSB +: 4];
            else if (!steer_sync_reg || PERIOD_START)
                steer_eff_reg <= steer_req_reg;
        end
    end

    // Instruction-cycle tick for the dead-band count
    assign tcy_tick = (tcy_cnt_reg == TCY_DIV_M1);

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            tcy_cnt_reg <= 4'h0;
        else if (CLK_EN)
            tcy_cnt_reg <= tcy_tick ? 4'h0 : tcy_cnt_reg + 4'h1;
    end

    // Half-bridge schedule: A follows PWM, B its complement
    assign db_sched = {~PWM_IN, PWM_IN};

    // Dead band: rising edges wait the count, falling edges pass at once
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            db_cnt_reg[0] <= '0;
            db_cnt_reg[1] <= '0;
            db_act_reg    <= 2'h0;
        end
        else if (CLK_EN)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (!half || !db_sched[i])
                begin
                    db_cnt_reg[i] <= db_count_reg;
                    db_act_reg[i] <= 1'b0;
                end
                else if (db_cnt_reg[i] != '0)
                begin
                    if (tcy_tick)
                        db_cnt_reg[i] <= db_cnt_reg[i] - 7'h01;
                end
                else
                begin
                    db_act_reg[i] <= 1'b1;
                end
            end
        end
    end

    // Pin ownership and the level each owned pin would carry
    always_comb
    begin
        own   = 4'h0;
        level = 4'h0;
        if (single)
        begin
            own   = steer_eff_reg;
            level = {4{PWM_IN}};
        end
        else if (half)
        begin
            own   = 4'h3;
            level = {2'h0, db_act_reg};
        end
        else if (pwm_mode)
        begin
            own   = 4'h1;
            level = {3'h0, PWM_IN};
        end
    end

    // Polarity: bit 1 for pair A/C, bit 0 for pair B/D
    assign low_act = {OUTPUT_POLARITY_FIELD[0], OUTPUT_POLARITY_FIELD[1],
                      OUTPUT_POLARITY_FIELD[0], OUTPUT_POLARITY_FIELD[1]};

    // Output flops; pins A and C use the A/C state, B and D the B/D state
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            pin_out_reg <= 4'h0;
            pin_oe_reg  <= 4'h0;
        end
        else if (CLK_EN)
        begin
            for (int i = 0; i < 4; i++)
            begin
                {pin_oe_reg[i], pin_out_reg[i]} <= psds_pin_drive(
                    own[i], halt, (i % 2 == 0) ? sd_ac_reg : sd_bd_reg,
                    level[i], low_act[i], PORT_DATA[i], PIN_DIRECTION_BITS[i]);
            end
        end
    end

    // Read data stands for exactly one cycle after the strobe
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            rdata_reg <= 8'h00;
        else if (CLK_EN)
        begin
            rdata_reg <= 8'h00;
            if (REG_RD)
            begin
                case (REG_ADDR)
                    ADDR_SHUTDOWN: rdata_reg <= {sd_flag_reg, sd_src_reg, sd_ac_reg, sd_bd_reg};
                    ADDR_RESTART:  rdata_reg <= {auto_rs_reg, db_count_reg};
                    ADDR_STEER:    rdata_reg <= {3'h0, steer_sync_reg, steer_req_reg};
                    default:       rdata_reg <= 8'h00;
                endcase
            end
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    flag_set_a: assert property (CLK_EN && sd_cond |=> sd_flag_reg)
        else $error("flag not set by shutdown condition");

    src_off_a: assert property (sd_src_reg == 3'h0 |-> !sd_cond)
        else $error("shutdown condition with sources disabled");

    ac_high_a: assert property (
        CLK_EN && halt && own[0] && sd_ac_reg == 2'b01 |=> PWM_PIN_OUT[0])
        else $error("pin A not high in shutdown");

    bd_tri_a: assert property (
        CLK_EN && halt && own[1] && sd_bd_reg[1] |=> !PWM_PIN_OE[1])
        else $error("pin B driven while tri-state selected");

    cmp2_hold_a: assert property (
        COMPARATOR2_SYNC_ENABLE && sd_src_reg == SRC_CMP2 && !cmp2_held_reg |-> !sd_cond)
        else $error("comparator two shutdown bypassed sync");

    write_ignore_a: assert property (
        CLK_EN && sd_cond && wr_shut && !REG_WDATA[SD_FLAG_BIT] |=> sd_flag_reg)
        else $error("flag cleared during condition");

    resume_period_a: assert property ($rose(run_reg) |-> $past(PERIOD_START))
        else $error("PWM resumed off a period start");

    auto_clear_a: assert property (
        CLK_EN && auto_rs_reg && sd_flag_reg && !sd_cond && !wr_shut
        && !STARTUP_RESTART_CLEAR |=> !sd_flag_reg)
        else $error("auto-restart did not clear flag");

    db_fall_a: assert property (CLK_EN && half && !PWM_IN |=> !db_act_reg[0])
        else $error("dead band delayed a falling edge");

    db_count_a: assert property (
        $rose(db_act_reg[0]) |-> $past(db_cnt_reg[0]) == 7'h00)
        else $error("output active before count expired");

    startup_clr_a: assert property (CLK_EN && STARTUP_RESTART_CLEAR |=> !auto_rs_reg)
        else $error("auto-restart kept under start-up clear");

    steer_sync_a: assert property (
        CLK_EN && steer_sync_reg && !wr_steer && !PERIOD_START |=> $stable(steer_eff_reg))
        else $error("steering changed off period start");

    port_keep_a: assert property (
        CLK_EN && !own[2] |=> PWM_PIN_OUT[2] == $past(PORT_DATA[2]))
        else $error("unowned pin C lost port data");

endmodule : psds_core

//--- core/psds_pkg.sv
/*
 * Shared constants and types for the PWM output-conditioning stage:
 * register offsets, field positions, reset values, source and mode codes.
 * Assumes the stage runs on the instruction clock of the PWM unit.
 */
package psds_pkg;

    // Register offsets on the local register port
    localparam logic [1:0] ADDR_SHUTDOWN = 2'h0;
    localparam logic [1:0] ADDR_RESTART  = 2'h1;
    localparam logic [1:0] ADDR_STEER    = 2'h2;

    // Field positions
    localparam int unsigned SD_FLAG_BIT = 7;
    localparam int unsigned SD_SRC_LSB  = 4;
    localparam int unsigned SD_AC_LSB   = 2;
    localparam int unsigned SD_BD_LSB   = 0;
    localparam int unsigned RS_AUTO_BIT = 7;
    localparam int unsigned RS_DB_LSB   = 0;
    localparam int unsigned ST_SYNC_BIT = 4;
    localparam int unsigned ST_EN_LSB   = 0;
    localparam int unsigned DB_W        = 7;

    // Reset values
    localparam logic [7:0] SHUTDOWN_RST = 8'h00;
    localparam logic [7:0] RESTART_RST  = 8'h00;
    localparam logic [4:0] STEER_RST    = 5'h01;

    // Timing: dead band counts instruction cycles
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned TCY_NS        = 40;
    localparam logic [3:0]  TCY_DIV_M1    =
        4'((TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);

    // Unit mode value that selects PWM
    localparam logic [1:0] MODE_PWM = 2'h3;

    // Shutdown source select codes
    typedef enum logic [2:0] {
        SRC_OFF      = 3'b000,
        SRC_CMP1     = 3'b001,
        SRC_CMP2     = 3'b010,
        SRC_CMP_ANY  = 3'b011,
        SRC_PIN      = 3'b100,
        SRC_PIN_CMP1 = 3'b101,
        SRC_PIN_CMP2 = 3'b110,
        SRC_PIN_ALL  = 3'b111
    } psds_src_t;

    // Output configuration codes
    typedef enum logic [1:0] {
        CFG_SINGLE   = 2'b00,
        CFG_FULL_FWD = 2'b01,
        CFG_HALF     = 2'b10,
        CFG_FULL_REV = 2'b11
    } psds_cfg_t;

endpackage : psds_pkg

//--- tb/psds_bridge_model.sv
/*
 * Behavioural model of the bridge switch drivers hung on the four pins.
 * Assumes pull-down resistors on every pin, so a released pin reads low.
 */
`timescale 1ns/1ns

module psds_bridge_model
(
    // Pins from the stage, D..A
    input  wire logic [3:0] PIN_OUT,
    input  wire logic [3:0] PIN_OE,
    // Resolved levels and hazard flag
    output logic      [3:0] PIN_LEVEL,
    output logic            SHOOT_THROUGH
);

    // Released pins fall to the pull-down; a stale driven value never lingers
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            PIN_LEVEL[i] = PIN_OE[i] ? PIN_OUT[i] : 1'b0;
    end

    // Both switches of the A/B leg on together would short the supply
    assign SHOOT_THROUGH = PIN_LEVEL[0] & PIN_LEVEL[1];

endmodule : psds_bridge_model

//--- tb/psds_core_tb.sv
/*
 * Self-checking bench for the PWM output-conditioning stage.
 * Assumes the bridge model is compiled first; clock enable is held high.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module psds_core_tb
    import psds_pkg::*;
;
    // Clock, reset and register port
    logic       REF_CLK, RST_B, CLK_EN, REG_WR, REG_RD;
    logic [1:0] REG_ADDR;
    logic [7:0] REG_WDATA, REG_RDATA;
    // PWM unit side and shutdown sources
    logic       PWM_IN, PERIOD_START, COMPARATOR_ONE, COMPARATOR_TWO, EXT_INT_PIN;
    logic       COMPARATOR2_SYNC_ENABLE, TIMER1_SYNC_PULSE, STARTUP_RESTART_CLEAR;
    logic [1:0] UNIT_MODE_FIELD, OUTPUT_POLARITY_FIELD, OUTPUT_CONFIG_FIELD;
    logic [3:0] PORT_DATA, PIN_DIRECTION_BITS, PWM_PIN_OUT, PWM_PIN_OE, lvl;
    // Bench state
    int         fail_count, n_tests, n;
    integer     seed = 38;
    logic [3:0] cur_sd, m, own;
    logic       sel, shoot, shoot_seen;
    logic [3:0] modes [5] = '{4'b1100, 4'b1101, 4'b1111, 4'b0000, 4'b1000};

    psds_core DUT (.REF_CLK(REF_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .PWM_IN(PWM_IN), .PERIOD_START(PERIOD_START),
        .UNIT_MODE_FIELD(UNIT_MODE_FIELD), .OUTPUT_POLARITY_FIELD(OUTPUT_POLARITY_FIELD),
        .OUTPUT_CONFIG_FIELD(OUTPUT_CONFIG_FIELD), .COMPARATOR_ONE(COMPARATOR_ONE),
        .COMPARATOR_TWO(COMPARATOR_TWO), .EXT_INT_PIN(EXT_INT_PIN),
        .COMPARATOR2_SYNC_ENABLE(COMPARATOR2_SYNC_ENABLE),
        .TIMER1_SYNC_PULSE(TIMER1_SYNC_PULSE), .STARTUP_RESTART_CLEAR(STARTUP_RESTART_CLEAR),
        .PORT_DATA(PORT_DATA), .PIN_DIRECTION_BITS(PIN_DIRECTION_BITS),
        .PWM_PIN_OUT(PWM_PIN_OUT), .PWM_PIN_OE(PWM_PIN_OE));

    psds_bridge_model bridge (.PIN_OUT(PWM_PIN_OUT), .PIN_OE(PWM_PIN_OE),
        .PIN_LEVEL(lvl), .SHOOT_THROUGH(shoot));

    // 25 MHz reference clock
    initial
    begin
        REF_CLK = 1'b0;
        forever #20 REF_CLK = ~REF_CLK;
    end

    // Sticky shoot-through monitor, cleared by the dead-band test
    always @(posedge REF_CLK)
        if (shoot === 1'b1)
            shoot_seen <= 1'b1;

    task automatic step(input int k);
        repeat (k) @(posedge REF_CLK);
        #1;
    endtask : step

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask : done

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        REG_WR    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the read edge
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e, input string nm);
        @(posedge REF_CLK);
        REG_RD   <= 1'b1;
        REG_ADDR <= a;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1;
        `CHK(nm, e, REG_RDATA)
    endtask : rd_chk

    task automatic period();
        @(posedge REF_CLK);
        PERIOD_START <= 1'b1;
        @(posedge REF_CLK);
        PERIOD_START <= 1'b0;
        step(3);
    endtask : period

    // Expected {enable, level} of pins D..A; released pins read the pull-down
    function automatic logic [7:0] exp_pins(input logic [3:0] ow, input logic halt,
                                            input logic [3:0] lv);
        logic [1:0] st;
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 4; i++)
        begin
            st     = i[0] ? cur_sd[1:0] : cur_sd[3:2];
            r[4+i] = ~PIN_DIRECTION_BITS[i];
            if (ow[i] && halt)
            begin
                r[4+i] = r[4+i] & ~st[1];
                r[i]   = st[0];
            end
            else
                r[i] = ow[i] ? lv[i] ^ OUTPUT_POLARITY_FIELD[!i[0]] : PORT_DATA[i];
            r[i] = r[i] & r[4+i];
        end
        return r;
    endfunction : exp_pins

    task automatic chk_pins(input logic [3:0] ow, input logic halt, input string nm);
        `CHK(nm, exp_pins(ow, halt, {4{PWM_IN}}), {PWM_PIN_OE, lvl})
    endtask : chk_pins

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // Hang guard, far beyond the expected run length
    initial
    begin
        repeat (40000) @(posedge REF_CLK);
        fail_count++;
        $display("[ERR] watchdog expected finish seen hang");
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        {RST_B, CLK_EN, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = 14'h1000;
        {PWM_IN, PERIOD_START, COMPARATOR_ONE, COMPARATOR_TWO, EXT_INT_PIN} = 5'b00001;
        {COMPARATOR2_SYNC_ENABLE, TIMER1_SYNC_PULSE, STARTUP_RESTART_CLEAR} = 3'b000;
        {UNIT_MODE_FIELD, OUTPUT_POLARITY_FIELD, OUTPUT_CONFIG_FIELD} = 6'h00;
        {PORT_DATA, PIN_DIRECTION_BITS, cur_sd, shoot_seen} = 13'h01e0;
        repeat (10) @(posedge REF_CLK);
        RST_B <= 1'b1;
        rd_chk(ADDR_SHUTDOWN, 8'h00, "shutdown reset");
        rd_chk(ADDR_RESTART, 8'h00, "restart reset");
        rd_chk(ADDR_STEER, 8'h01, "steer reset");
        wr(2'h3, 8'hff);
        rd_chk(2'h3, 8'h00, "unmapped");
        done("reset");
        // Random masks across the mode table; only 11/00 may steer
        for (int k = 0; k < 20; k++)
        begin
            m = 4'($random(seed));
            wr(ADDR_STEER, {4'h0, m});
            @(posedge REF_CLK);
            {UNIT_MODE_FIELD, OUTPUT_CONFIG_FIELD} <= modes[k % 5];
            OUTPUT_POLARITY_FIELD <= 2'($random(seed));
            PORT_DATA             <= 4'($random(seed));
            PIN_DIRECTION_BITS    <= 4'($random(seed));
            PWM_IN                <= 1'($random(seed));
            step(3);
            own = (k % 5 == 0) ? m : ((k % 5 < 3) ? 4'h1 : 4'h0);
            chk_pins(own, 1'b0, "steer pins");
        end
        done("steering");
        // Period-synchronised steering change
        @(posedge REF_CLK);
        {UNIT_MODE_FIELD, OUTPUT_CONFIG_FIELD} <= 4'b1100;
        PIN_DIRECTION_BITS <= 4'h0;
        wr(ADDR_STEER, 8'h05);
        wr(ADDR_STEER, 8'h1a);
        step(3);
        chk_pins(4'h5, 1'b0, "sync held");
        rd_chk(ADDR_STEER, 8'h1a, "sync reg");
        period();
        chk_pins(4'ha, 1'b0, "sync applied");
        done("steer sync");
        // Every source code against every single source; {pin, C2, C1}
        for (int s = 0; s < 8; s++)
            for (int c = 0; c < 3; c++)
            begin
                m      = 4'($random(seed));
                cur_sd = 4'($random(seed));
                sel    = s[c];
                wr(ADDR_STEER, {4'h0, m});
                wr(ADDR_SHUTDOWN, {1'b0, 3'(s), cur_sd});
                @(posedge REF_CLK);
                {EXT_INT_PIN, COMPARATOR_TWO, COMPARATOR_ONE} <= 3'b100 ^ (3'b001 << c);
                PWM_IN <= 1'($random(seed));
                step(3);
                rd_chk(ADDR_SHUTDOWN, {sel, 3'(s), cur_sd}, "flag set");
                chk_pins(m, sel, "shutdown pins");
                wr(ADDR_SHUTDOWN, {1'b0, 3'(s), cur_sd});
                rd_chk(ADDR_SHUTDOWN, {sel, 3'(s), cur_sd}, "flag held");
                @(posedge REF_CLK);
                {EXT_INT_PIN, COMPARATOR_TWO, COMPARATOR_ONE} <= 3'b100;
                step(3);
                chk_pins(m, sel, "latched");
                wr(ADDR_SHUTDOWN, {1'b0, 3'(s), cur_sd});
                step(2);
                chk_pins(m, sel, "wait period");
                period();
                chk_pins(m, 1'b0, "resumed");
            end
        done("shutdown sources");
        // Software-raised event with the sources disabled
        wr(ADDR_SHUTDOWN, {1'b1, 3'h0, cur_sd});
        step(2);
        rd_chk(ADDR_SHUTDOWN, {1'b1, 3'h0, cur_sd}, "soft flag");
        chk_pins(m, 1'b1, "soft pins");
        wr(ADDR_SHUTDOWN, {1'b0, 3'h0, cur_sd});
        period();
        done("soft event");
        // Auto-restart, then its forced clear
        wr(ADDR_RESTART, 8'h80);
        wr(ADDR_SHUTDOWN, {1'b0, 3'h4, cur_sd});
        @(posedge REF_CLK);
        EXT_INT_PIN <= 1'b0;
        step(6);
        rd_chk(ADDR_SHUTDOWN, {1'b1, 3'h4, cur_sd}, "auto held");
        @(posedge REF_CLK);
        EXT_INT_PIN <= 1'b1;
        step(3);
        rd_chk(ADDR_SHUTDOWN, {1'b0, 3'h4, cur_sd}, "auto cleared");
        period();
        chk_pins(m, 1'b0, "auto resumed");
        @(posedge REF_CLK);
        STARTUP_RESTART_CLEAR <= 1'b1;
        step(2);
        rd_chk(ADDR_RESTART, 8'h00, "restart clear");
        @(posedge REF_CLK);
        STARTUP_RESTART_CLEAR <= 1'b0;
        done("auto restart");
        // Comparator two seen only through the timer sample
        wr(ADDR_SHUTDOWN, {1'b0, 3'h2, cur_sd});
        @(posedge REF_CLK);
        COMPARATOR2_SYNC_ENABLE <= 1'b1;
        COMPARATOR_TWO          <= 1'b1;
        step(4);
        rd_chk(ADDR_SHUTDOWN, {1'b0, 3'h2, cur_sd}, "c2 delayed");
        @(posedge REF_CLK);
        TIMER1_SYNC_PULSE <= 1'b1;
        @(posedge REF_CLK);
        TIMER1_SYNC_PULSE <= 1'b0;
        COMPARATOR_TWO    <= 1'b0;
        step(3);
        rd_chk(ADDR_SHUTDOWN, {1'b1, 3'h2, cur_sd}, "c2 synced");
        @(posedge REF_CLK);
        TIMER1_SYNC_PULSE <= 1'b1;
        @(posedge REF_CLK);
        TIMER1_SYNC_PULSE       <= 1'b0;
        COMPARATOR2_SYNC_ENABLE <= 1'b0;
        wr(ADDR_SHUTDOWN, 8'h00);
        period();
        done("comparator sync");
        // Half bridge: counts 0, 1, the maximum and random ones
        @(posedge REF_CLK);
        {UNIT_MODE_FIELD, OUTPUT_CONFIG_FIELD} <= 4'b1110;
        OUTPUT_POLARITY_FIELD <= 2'h0;
        PWM_IN                <= 1'b0;
        for (int k = 0; k < 6; k++)
        begin
            n = (k < 2) ? k : ((k == 2) ? 127 : 2 + {$random(seed)} % 19);
            wr(ADDR_RESTART, {1'b0, 7'(n)});
            step(135);
            // Clear off the edge, once the single-mode pins have left
            if (k == 0)
                shoot_seen = 1'b0;
            @(posedge REF_CLK);
            PWM_IN <= 1'b1;
            step(n + 1);
            `CHK("rise early", {n == 0, 1'b0}, lvl[1:0])
            step(1);
            `CHK("rise late", 2'b01, lvl[1:0])
            @(posedge REF_CLK);
            PWM_IN <= 1'b0;
            step(n + 1);
            `CHK("fall early", {1'b0, n == 0}, lvl[1:0])
            step(1);
            `CHK("fall late", 2'b10, lvl[1:0])
        end
        `CHK("overlap", 1'b0, shoot_seen)
        done("dead band");
        tally_and_finish();
    end

endmodule : psds_core_tb
